// [pkg/wdt_pkg.sv]
// Constants shared by the watchdog timer: register map, field positions,
// reset values and bus slave states.
// Assumes a 32-bit APB bus with byte addresses and one word per register.

package wdt_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_RELOAD = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_ICLR   = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_RIS    = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_MIS    = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_GUARD  = 12'hC00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CTRL_IRQ_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int STS_BIT      = 0;
  localparam int GUARD_BIT    = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Key and reset values
  localparam logic [DATA_W-1:0] GUARD_KEY  = 32'h1ACCE551;
  localparam logic [DATA_W-1:0] RELOAD_RST = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] COUNT_RST  = 32'hFFFFFFFF;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h00000000;

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock: nominal tick rate in Hz
  localparam int SLOW_CLK_HZ = 32768;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave states
  typedef enum logic [1:0]
  {
    BUS_IDLE   = 2'b00,
    BUS_ACCESS = 2'b01,
    BUS_DONE   = 2'b10
  } bus_state_e;

endpackage : wdt_pkg

// [src/tick_sync.sv]
// Brings the free slow clock pin into the system clock domain and
// turns each rising edge into a one-cycle tick.
// Assumes the system clock is far faster than the slow clock.

`timescale 1ns/1ps

module tick_sync
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Slow clock pin
  input  wire logic slow_clk_pin,
  // Tick in system domain
  output logic      tick
);

  ////////////////////////////////////////////////////////////////////////////
  logic meta_r;
  logic sync_r;
  logic prev_r;
  logic tick_r;
  logic tick_nxt;

  // Edge detect looks only at the second stage
  assign tick_nxt = sync_r & ~prev_r;
  assign tick     = tick_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
      tick_r <= 1'b0;
    end
    else
    begin
      meta_r <= slow_clk_pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
      tick_r <= tick_nxt; // R17
    end
  end

endmodule : tick_sync

// [src/watchdog_timer.sv]
// Watchdog timer: 32-bit down counter on slow clock ticks, interrupt at
// zero, system reset on a second zero while the interrupt is pending.
// Assumes an APB master on SYS_CLK and a free running slow clock pin.
//
// Operation
// R1: 32-bit counter decrements once per slow clock tick of about 32.768 kHz.
// R2: Interrupt period is reload value plus one ticks.
// R3: At zero set interrupt status, reload and keep counting down.
// R4: Clearing the pending interrupt also reloads the counter.
// R5: Zero again with status still set asserts reset if reset enabled.
// R6: Control bit 0 enables interrupt, bit 1 enables reset output.
// R7: Interrupt disabled halts counter; enabling restarts from reload value.
// R8: Writing reload register restarts count from the new value.
// R9: Count register reads live count; writes ignored.
// R10: Any write to clear register clears status and reloads; reads zero.
// R11: Raw status register shows unmasked status in bit 0; read only.
// R12: Masked status register shows status gated by interrupt enable.
// R13: Key to guard register unlocks other writes; other values lock.
// R14: Guard register reads 1 when locked, 0 when writes allowed.
// R15: Reset gives all ones reload and count, control bits zero.
// R16: Guard register accepts writes whatever the lock state.
// R17: Slow clock ticks cross safely into the register clock domain.
//
// The APB interface to the registers was decided locally.

`timescale 1ns/1ps

module watchdog_timer
(
  // Clock and reset
  input  wire logic                        SYS_CLK,
  input  wire logic                        RESET_N,
  // Slow count clock pin
  input  wire logic                        SLOW_CLK,
  // APB slave
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [wdt_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [wdt_pkg::DATA_W-1:0] PWDATA,
  output logic      [wdt_pkg::DATA_W-1:0] PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  // Watchdog outputs
  output logic                             WDT_IRQ,
  output logic                             WDT_RESET_OUT
);

  import wdt_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic                tick;

  bus_state_e          bus_state_r;
  bus_state_e          bus_state_nxt;
  logic                pready_r;
  logic                pslverr_r;
  logic [DATA_W-1:0]   prdata_r;
  logic [DATA_W-1:0]   prdata_nxt;

  logic [DATA_W-1:0]   reload_r;
  logic [DATA_W-1:0]   reload_nxt;
  logic [DATA_W-1:0]   count_r;
  logic [DATA_W-1:0]   count_nxt;
  logic                irq_gen_on_r;
  logic                irq_gen_on_nxt;
  logic                reboot_out_on_r;
  logic                reboot_out_on_nxt;
  logic                irq_sts_r;
  logic                irq_sts_nxt;
  logic                locked_r;
  logic                locked_nxt;
  logic                irq_out_r;
  logic                reset_out_r;
  logic                reset_out_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock tick, synchronised into SYS_CLK

  tick_sync u_tick_sync
  (
    .clk          (SYS_CLK),
    .reset_n      (RESET_N),
    .slow_clk_pin (SLOW_CLK),
    .tick         (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire sel_reload = (PADDR == OFS_RELOAD);
  wire sel_count  = (PADDR == OFS_COUNT);
  wire sel_ctrl   = (PADDR == OFS_CTRL);
  wire sel_iclr   = (PADDR == OFS_ICLR);
  wire sel_ris    = (PADDR == OFS_RIS);
  wire sel_mis    = (PADDR == OFS_MIS);
  wire sel_guard  = (PADDR == OFS_GUARD);
  wire sel_any    = sel_reload | sel_count | sel_ctrl | sel_iclr |
                    sel_ris | sel_mis | sel_guard;

  ////////////////////////////////////////////////////////////////////////////
  // Bus phases
  // One wait state: the answer is registered so PRDATA comes from a flop.

  wire access_first = PSEL & PENABLE & (bus_state_r == BUS_IDLE);
  wire access_done  = PSEL & PENABLE & (bus_state_r == BUS_ACCESS);
  wire wr_commit    = access_done & PWRITE;

  // Lock gates everything but the guard register itself
  wire wr_allowed   = ~locked_r | sel_guard; // R13 R16

  wire wr_reload    = wr_commit & wr_allowed & sel_reload; // R8
  wire wr_ctrl      = wr_commit & wr_allowed & sel_ctrl;
  wire wr_iclr      = wr_commit & wr_allowed & sel_iclr; // R10
  wire wr_guard     = wr_commit & sel_guard; // R16

  ////////////////////////////////////////////////////////////////////////////
  // Read mux

  wire [DATA_W-1:0] ctrl_word = {{(DATA_W-2){1'b0}}, reboot_out_on_r, irq_gen_on_r}; // R6
  wire [DATA_W-1:0] ris_word  = {{(DATA_W-1){1'b0}}, irq_sts_r}; // R11
  wire [DATA_W-1:0] mis_word  = {{(DATA_W-1){1'b0}}, irq_sts_r & irq_gen_on_r}; // R12
  wire [DATA_W-1:0] lock_word = {{(DATA_W-1){1'b0}}, locked_r}; // R14

  wire [DATA_W-1:0] rd_word =
    sel_reload ? reload_r  :
    sel_count  ? count_r   : // R9
    sel_ctrl   ? ctrl_word :
    sel_iclr   ? ZERO_WORD : // R10
    sel_ris    ? ris_word  :
    sel_mis    ? mis_word  :
    sel_guard  ? lock_word :
                 ZERO_WORD;

  ////////////////////////////////////////////////////////////////////////////
  // Bus state machine

  always_comb
  begin
    bus_state_nxt = bus_state_r;
    prdata_nxt    = prdata_r;
    case (bus_state_r)
      BUS_IDLE:
      begin
        if (access_first)
        begin
          bus_state_nxt = BUS_ACCESS;
          prdata_nxt    = PWRITE ? ZERO_WORD : rd_word;
        end
      end
      BUS_ACCESS:
      begin
        if (access_done)
        begin
          bus_state_nxt = BUS_DONE;
          prdata_nxt    = ZERO_WORD;
        end
      end
      BUS_DONE:
      begin
        bus_state_nxt = BUS_IDLE;
      end
      default:
      begin
        bus_state_nxt = BUS_IDLE;
        prdata_nxt    = ZERO_WORD;
      end
    endcase
  end

  // BUS_DONE lets PENABLE fall before a new access is seen
  wire pready_nxt  = access_first;
  wire pslverr_nxt = access_first & ~sel_any;

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      bus_state_r <= BUS_IDLE;
      prdata_r    <= ZERO_WORD;
      pready_r    <= 1'b0;
      pslverr_r   <= 1'b0;
    end
    else
    begin
      bus_state_r <= bus_state_nxt;
      prdata_r    <= prdata_nxt;
      pready_r    <= pready_nxt;
      pslverr_r   <= pslverr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and guard registers

  always_comb
  begin
    irq_gen_on_nxt    = irq_gen_on_r;
    reboot_out_on_nxt = reboot_out_on_r;
    reload_nxt        = reload_r;
    locked_nxt        = locked_r;
    if (wr_ctrl)
    begin
      irq_gen_on_nxt    = PWDATA[CTRL_IRQ_BIT]; // R6
      reboot_out_on_nxt = PWDATA[CTRL_RST_BIT]; // R6
    end
    if (wr_reload)
    begin
      reload_nxt = PWDATA;
    end
    if (wr_guard)
    begin
      locked_nxt = (PWDATA != GUARD_KEY); // R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter events

  wire count_zero = (count_r == ZERO_WORD);
  wire tick_live  = tick & irq_gen_on_r; // R7
  wire hit_zero   = tick_live & count_zero; // R2 R3
  wire tick_dec   = tick_live & ~count_zero; // R1

  // Enabling restarts from the reload value, not the held count
  wire en_rise    = wr_ctrl & PWDATA[CTRL_IRQ_BIT] & ~irq_gen_on_r; // R7

  // Zero again while still pending is the reboot condition
  wire reboot_hit = hit_zero & irq_sts_r & reboot_out_on_r; // R5

  ////////////////////////////////////////////////////////////////////////////
  // Counter and status next values
  // A reload write wins over every other source of the count.

  always_comb
  begin
    count_nxt = count_r;
    if (wr_reload)
    begin
      count_nxt = PWDATA; // R8
    end
    else if (wr_iclr)
    begin
      count_nxt = reload_r; // R4 R10
    end
    else if (en_rise)
    begin
      count_nxt = reload_r; // R7
    end
    else if (hit_zero)
    begin
      count_nxt = reload_r; // R3
    end
    else if (tick_dec)
    begin
      count_nxt = count_r - 32'h00000001; // R1
    end
  end

  // Set wins over clear so a zero in the clearing cycle is kept
  always_comb
  begin
    irq_sts_nxt = irq_sts_r;
    if (hit_zero)
    begin
      irq_sts_nxt = 1'b1; // R3
    end
    else if (wr_iclr)
    begin
      irq_sts_nxt = 1'b0; // R10
    end
  end

  // Reset output holds until the system reset comes back
  assign reset_out_nxt = reset_out_r | reboot_hit; // R5

  ////////////////////////////////////////////////////////////////////////////
  // Core registers

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      reload_r        <= RELOAD_RST; // R15
      count_r         <= COUNT_RST; // R15
      irq_gen_on_r    <= 1'b0; // R15
      reboot_out_on_r <= 1'b0; // R15
      irq_sts_r       <= 1'b0;
      locked_r        <= 1'b0;
    end
    else
    begin
      reload_r        <= reload_nxt;
      count_r         <= count_nxt;
      irq_gen_on_r    <= irq_gen_on_nxt;
      reboot_out_on_r <= reboot_out_on_nxt;
      irq_sts_r       <= irq_sts_nxt;
      locked_r        <= locked_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output flops
  // Interrupt line is registered from the next status and enable values, so it changes on the same edge as the status bit.

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      irq_out_r   <= 1'b0;
      reset_out_r <= 1'b0;
    end
    else
    begin
      irq_out_r   <= irq_sts_nxt & irq_gen_on_nxt; // R12
      reset_out_r <= reset_out_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port drive

  assign PRDATA        = prdata_r;
  assign PREADY        = pready_r;
  assign PSLVERR       = pslverr_r;
  assign WDT_IRQ       = irq_out_r;
  assign WDT_RESET_OUT = reset_out_r;

endmodule : watchdog_timer

// [tb/watchdog_timer_checker.sv]
// Checker for the watchdog timer: bus answer and output relations.
// Sees only the top module's ports; bound in below.

`timescale 1ns/1ps

module watchdog_timer_checker
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic                        SYS_CLK,
  input wire logic                        RESET_N,
  // APB
  input wire logic                        PSEL,
  input wire logic                        PENABLE,
  input wire logic                        PWRITE,
  input wire logic [wdt_pkg::ADDR_W-1:0] PADDR,
  input wire logic [wdt_pkg::DATA_W-1:0] PRDATA,
  input wire logic                        PREADY,
  input wire logic                        PSLVERR,
  // Outputs
  input wire logic                        WDT_IRQ,
  input wire logic                        WDT_RESET_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  wire rd     = PREADY && !PWRITE;
  wire mapped = PADDR inside {OFS_RELOAD, OFS_COUNT, OFS_CTRL, OFS_ICLR, OFS_RIS, OFS_MIS, OFS_GUARD};

  ////////////////////////////////////////////////////////////////////////////
  sequence s_access;
    PSEL && $rose(PENABLE);
  endsequence

  sequence s_answer;
    PREADY ##1 !PREADY;
  endsequence

  a_ready_time: assert property (s_access |=> s_answer) else $error("ready not one pulse after access");
  a_ready_idle: assert property (!(PSEL && PENABLE) |=> !PREADY) else $error("ready without access");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == ZERO_WORD) else $error("read data outside answer");
  a_err_map: assert property (PREADY |-> PSLVERR == !mapped) else $error("error flag wrong for address");
  a_clear_reads: assert property (rd && PADDR == OFS_ICLR |-> PRDATA == ZERO_WORD) else $error("clear reg read");
  a_sts_bits: assert property (rd && (PADDR == OFS_RIS || PADDR == OFS_MIS) |-> PRDATA[31:1] == '0)
    else $error("status upper bits set");
  a_mis_pin: assert property (rd && PADDR == OFS_MIS |-> PRDATA[0] == $past(WDT_IRQ))
    else $error("masked status differs from irq");
  a_guard_bits: assert property (rd && PADDR == OFS_GUARD |-> PRDATA[31:1] == '0) else $error("guard bits");
  a_ctrl_bits: assert property (rd && PADDR == OFS_CTRL |-> PRDATA[31:2] == '0) else $error("ctrl bits");
  a_rst_sticky: assert property (WDT_RESET_OUT |=> WDT_RESET_OUT) else $error("reset out dropped");
  a_rst_cause: assert property ($rose(WDT_RESET_OUT) |-> $past(WDT_IRQ)) else $error("reset without irq");

endmodule : watchdog_timer_checker

bind watchdog_timer watchdog_timer_checker u_watchdog_timer_checker
(
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .WDT_IRQ(WDT_IRQ), .WDT_RESET_OUT(WDT_RESET_OUT)
);

// [tb/watchdog_timer_tb.sv]
// Testbench for the watchdog timer: registers, guard, count, irq, reset.
// Drives APB and the slow clock pin itself; pin is still between ticks.

`timescale 1ns/1ps

module watchdog_timer_tb;
  import wdt_pkg::*;

  logic              SYS_CLK  = 1'b0;
  logic              RESET_N  = 1'b0;
  logic              SLOW_CLK = 1'b0;
  logic              PSEL     = 1'b0;
  logic              PENABLE  = 1'b0;
  logic              PWRITE   = 1'b0;
  logic [ADDR_W-1:0] PADDR    = 12'h000;
  logic [DATA_W-1:0] PWDATA   = 32'h00000000;
  logic [DATA_W-1:0] PRDATA;
  logic              PREADY;
  logic              PSLVERR;
  logic              WDT_IRQ;
  logic              WDT_RESET_OUT;
  logic [DATA_W-1:0] rq;
  logic              re;
  int                bad_count = 0;
  int                n_checks  = 0;

  watchdog_timer u_watchdog_timer
  (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .SLOW_CLK(SLOW_CLK), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .WDT_IRQ(WDT_IRQ), .WDT_RESET_OUT(WDT_RESET_OUT)
  );

  initial forever #2.5 SYS_CLK = ~SYS_CLK;

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Slave answer time is not assumed; bounded wait on PREADY
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge SYS_CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    k = 0;
    do
    begin
      @(posedge SYS_CLK);
      k++;
    end while (PREADY !== 1'b1 && k < 20);
    rq = PRDATA;
    re = PSLVERR;
    // A slave that never answers ends the run through the common verdict
    if (PREADY !== 1'b1)
    begin
      bad_count++;
      tally_and_finish;
    end
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rq, exp);
  endtask : rdc

  // One slow edge every 16 fast cycles; ample margin for the synchroniser
  task tick(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge SYS_CLK);
      SLOW_CLK <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
      SLOW_CLK <= 1'b0;
    end
  endtask : tick

  ////////////////////////////////////////////////////////////////////////////
  task t_resets;
    rdc(OFS_RELOAD, RELOAD_RST);
    rdc(OFS_COUNT, COUNT_RST);
    rdc(OFS_CTRL, ZERO_WORD);
    rdc(OFS_GUARD, ZERO_WORD);
    rdc(12'h018, ZERO_WORD);
    chk({31'h0, re}, 32'h00000001);
    $display("t_resets done");
  endtask : t_resets

  task t_guard;
    apb(1'b1, OFS_GUARD, 32'h00000000);
    rdc(OFS_GUARD, 32'h00000001);
    apb(1'b1, OFS_RELOAD, 32'h00000005);
    rdc(OFS_RELOAD, RELOAD_RST);
    apb(1'b1, OFS_GUARD, GUARD_KEY);
    rdc(OFS_GUARD, ZERO_WORD);
    apb(1'b1, OFS_RELOAD, 32'h00000003);
    rdc(OFS_COUNT, 32'h00000003);
    $display("t_guard done");
  endtask : t_guard

  task t_count;
    apb(1'b1, OFS_CTRL, 32'h00000001);
    tick(2);
    rdc(OFS_COUNT, 32'h00000001);
    apb(1'b1, OFS_COUNT, 32'h00000009);
    rdc(OFS_COUNT, 32'h00000001);
    tick(1);
    rdc(OFS_RIS, ZERO_WORD);
    tick(1);
    rdc(OFS_RIS, 32'h00000001);
    rdc(OFS_COUNT, 32'h00000003);
    apb(1'b1, OFS_RIS, 32'h00000000);
    rdc(OFS_RIS, 32'h00000001);
    tick(1);
    apb(1'b1, OFS_CTRL, 32'h00000000);
    rdc(OFS_MIS, ZERO_WORD);
    chk({31'h0, WDT_IRQ}, 32'h00000000);
    tick(2);
    rdc(OFS_COUNT, 32'h00000002);
    apb(1'b1, OFS_CTRL, 32'h00000001);
    rdc(OFS_COUNT, 32'h00000003);
    rdc(OFS_MIS, 32'h00000001);
    tick(1);
    apb(1'b1, OFS_ICLR, 32'h5A5A5A5A);
    rdc(OFS_RIS, ZERO_WORD);
    rdc(OFS_COUNT, 32'h00000003);
    $display("t_count done");
  endtask : t_count

  task t_reboot;
    apb(1'b1, OFS_RELOAD, 32'h00000001);
    tick(4);
    chk({31'h0, WDT_RESET_OUT}, 32'h00000000);
    apb(1'b1, OFS_CTRL, 32'h00000003);
    tick(1);
    chk({31'h0, WDT_RESET_OUT}, 32'h00000000);
    tick(1);
    chk({31'h0, WDT_RESET_OUT}, 32'h00000001);
    RESET_N <= 1'b0;
    repeat (5) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    chk({31'h0, WDT_RESET_OUT}, 32'h00000000);
    rdc(OFS_COUNT, COUNT_RST);
    $display("t_reboot done");
  endtask : t_reboot

  ////////////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // Tests need well under 10 us
  initial
  begin
    #50000;
    bad_count++;
    tally_and_finish;
  end

  initial
  begin
    repeat (5) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    t_resets;
    t_guard;
    t_count;
    t_reboot;
    tally_and_finish;
  end

endmodule : watchdog_timer_tb
